// *** ups_pkg.sv ***
// Package with the register map, field positions and carriers of the block.
// Functional notes
// - Frames: 8 data, 7 data+parity, 9 data, or 8 data+parity; one stop.
// - Parity covers low 7 or 8 data bits; even when odd-select 0, odd when 1.
// - With parity on, transmitted word MSB is replaced by the parity bit.
// - With parity on, mismatched received word sets parity fault, may interrupt.
// - Address-mark wake-up looks at the top data bit, never the parity bit.
// - Wait: enabled events wake. Halt: hold registers, stop serial, no wake.
// - One shared interrupt; each event needs its enable and a clear mask.
// - Transmit-empty, bit 7, sets on holding-to-shifter move; blocks transfers.
// - Transmit-done, bit 6, sets after data frames only; same clear as bit 7.
// - Receive-full, bit 5, sets when a word is readable; status then read clears.
// - Idle, bit 4, sets on idle line; not again until receive-full sets.
// - Overrun, bit 3, sets if word completes while full; holding kept.
// - Noise, bit 2, sets on noisy frame; no interrupt of its own.
// - Framing, bit 1, sets on framing fault; suppressed when overrun occurs.
// - Parity fault, bit 0, clears on status read then any data access.
// - Status reads c0 after reset.
// - Long words: control bit 7 takes ninth received bit, bit 6 gives ninth sent.
// - Low-power bit 5 stops prescalers and outputs after the current byte.
// - Control bit 4 picks 8 or 9 data bits; never changed mid-transfer.
// - Control bit 3 picks wake-up: 0 idle line, 1 address mark.
// - Control bit 2 enables parity; takes effect after the byte in progress.
// - Bit 1 odd/even, bit 0 parity interrupt; selection applies from next byte.
// - Receive interrupt enable gates overrun as well as receive-full.
package ups_pkg;

	// Register byte addresses on the bus.
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_DATA   = 8'h04;
	localparam logic [7:0] ADDR_CTRL1  = 8'h08;

	// Status register field positions.
	localparam int BIT_TXE   = 7;
	localparam int BIT_TXD   = 6;
	localparam int BIT_RXF   = 5;
	localparam int BIT_IDLE  = 4;
	localparam int BIT_OVR   = 3;
	localparam int BIT_NOISE = 2;
	localparam int BIT_FRAME = 1;
	localparam int BIT_PAR   = 0;

	// First control register field positions.
	localparam int CTL_RX9   = 7;
	localparam int CTL_TX9   = 6;
	localparam int CTL_LPOFF = 5;
	localparam int CTL_LONG  = 4;
	localparam int CTL_WAKE  = 3;
	localparam int CTL_PON   = 2;
	localparam int CTL_PODD  = 1;
	localparam int CTL_PIE   = 0;

	// Reset values.
	localparam logic [7:0] STATUS_RST = 8'hc0;
	localparam logic [7:0] CTRL1_RST  = 8'h00;

	// Frame format latched per direction at byte boundaries.
	typedef struct packed {
		logic longWord;
		logic parityOn;
		logic parityOdd;
	} ups_cfg_t;

	// Events from the receive shifter.
	typedef struct packed {
		logic       done;
		logic [8:0] word;
		logic       noise;
		logic       frameErr;
		logic       idle;
	} ups_rx_evt_t;

	// Events from the transmit shifter.
	typedef struct packed {
		logic load;
		logic frameDone;
		logic frameIsData;
	} ups_tx_evt_t;

	// Interrupt enables held in the second control register.
	typedef struct packed {
		logic txEmpty;
		logic txDone;
		logic rx;
		logic idle;
	} ups_irq_en_t;

	// Parity bit that completes the chosen parity over the low data bits.
	function automatic logic parityBit(input logic [8:0] w, input ups_cfg_t c);
		logic ones;
		ones = c.longWord ? ^w[7:0] : ^w[6:0];
		return ones ^ c.parityOdd;
	endfunction

endpackage

// *** ups_parity_status.sv ***
// Parity, status flags and first control register of the serial interface.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module ups_parity_status (
	// Clock and reset.
	input  wire logic                 clock,
	input  wire logic                 sys_rst,
	// APB slave.
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Transmit shifter side.
	input  wire ups_pkg::ups_tx_evt_t txEvt,
	input  wire logic                 txBusy,
	output logic      [8:0]           txWord,
	output logic                      txWordValid,
	// Receive shifter side.
	input  wire ups_pkg::ups_rx_evt_t rxEvt,
	input  wire logic                 rxBusy,
	output logic                      rxAddrMark,
	output logic                      wakeByAddr,
	// System and interrupt side.
	input  wire ups_pkg::ups_irq_en_t irqEn,
	input  wire logic                 irqMask,
	input  wire logic                 waitMode,
	input  wire logic                 haltMode,
	output logic                      irqReq,
	output logic                      wakeReq,
	output logic                      serialRun
);

	// Whole state of the block.
	typedef struct packed {
		logic [7:0]        status;
		logic [7:0]        ctrl;
		logic [7:0]        txHold;
		logic              holdFull;
		logic [7:0]        rxHold;
		ups_pkg::ups_cfg_t txCfg;
		ups_pkg::ups_cfg_t rxCfg;
		logic              armAny;
		logic              armRead;
		logic              idleArmed;
		logic [8:0]        txWord;
		logic              txValid;
		logic              addrMark;
		logic              irq;
		logic              wake;
		logic              run;
		logic              pready;
		logic              pslverr;
		logic [7:0]        prdata;
	} ups_state_t;

	ups_state_t s_r;
	ups_state_t s_nxt;

	logic apbDone;
	logic stAcc;
	logic dataWr;
	logic dataRd;
	logic ctrlWr;
	logic txClr;
	logic rxClr;
	logic parClr;
	logic rxMismatch;
	logic pending;
	ups_pkg::ups_cfg_t ctlCfg;

	// Bus decode; a transfer completes on the edge where pready is seen.
	assign apbDone = psel & penable & s_r.pready & ~s_r.pslverr;
	assign stAcc   = apbDone & (paddr == ups_pkg::ADDR_STATUS) & ~haltMode;
	assign dataWr  = apbDone & (paddr == ups_pkg::ADDR_DATA) & pwrite
		& ~haltMode;
	assign dataRd  = apbDone & (paddr == ups_pkg::ADDR_DATA) & ~pwrite
		& ~haltMode;
	assign ctrlWr  = apbDone & (paddr == ups_pkg::ADDR_CTRL1) & pwrite
		& ~haltMode;

	// Clear sequences complete only on a data access after a status access.
	assign txClr  = s_r.armAny & dataWr;
	assign rxClr  = s_r.armAny & dataRd;
	assign parClr = s_r.armRead & (dataWr | dataRd);

	// Live format requested by software in the control register.
	assign ctlCfg = '{longWord:  s_r.ctrl[ups_pkg::CTL_LONG],
	                  parityOn:  s_r.ctrl[ups_pkg::CTL_PON],
	                  parityOdd: s_r.ctrl[ups_pkg::CTL_PODD]};

	// Received word fails when its ones count disagrees with the selection.
	assign rxMismatch = s_r.rxCfg.longWord
		? ((^rxEvt.word[8:0]) != s_r.rxCfg.parityOdd)
		: ((^rxEvt.word[7:0]) != s_r.rxCfg.parityOdd);

	// Any enabled event; noise and framing stand behind receive-full.
	assign pending =
		(s_r.status[ups_pkg::BIT_TXE] & irqEn.txEmpty) |
		(s_r.status[ups_pkg::BIT_TXD] & irqEn.txDone) |
		((s_r.status[ups_pkg::BIT_RXF] | s_r.status[ups_pkg::BIT_OVR])
			& irqEn.rx) |
		(s_r.status[ups_pkg::BIT_IDLE] & irqEn.idle) |
		(s_r.status[ups_pkg::BIT_PAR] & s_r.ctrl[ups_pkg::CTL_PIE]);

	// Next state: clears are applied before sets so a status-bit set always wins.
	always_comb begin
		s_nxt = s_r;
		s_nxt.pready  = psel & ~penable;
		s_nxt.pslverr = 1'b0;
		s_nxt.prdata  = 8'h00;
		if (psel & ~penable) begin
			case (paddr)
				ups_pkg::ADDR_STATUS: s_nxt.prdata = s_r.status;
				ups_pkg::ADDR_DATA:   s_nxt.prdata = s_r.rxHold;
				ups_pkg::ADDR_CTRL1:  s_nxt.prdata = s_r.ctrl;
				default:              s_nxt.pslverr = 1'b1;
			endcase
		end
		// Halt freezes every register except the bus answer and the request, wake-up and run flags set below.
		if (!haltMode) begin
			if (txClr) begin
				s_nxt.status[ups_pkg::BIT_TXE] = 1'b0;
				s_nxt.status[ups_pkg::BIT_TXD] = 1'b0;
			end
			if (rxClr) begin
				s_nxt.status[ups_pkg::BIT_RXF]   = 1'b0;
				s_nxt.status[ups_pkg::BIT_IDLE]  = 1'b0;
				s_nxt.status[ups_pkg::BIT_OVR]   = 1'b0;
				s_nxt.status[ups_pkg::BIT_NOISE] = 1'b0;
				s_nxt.status[ups_pkg::BIT_FRAME] = 1'b0;
			end
			if (parClr) begin
				s_nxt.status[ups_pkg::BIT_PAR] = 1'b0;
			end
			// Any data access ends the armed sequence; a status access starts it.
			if (dataWr | dataRd) begin
				s_nxt.armAny  = 1'b0;
				s_nxt.armRead = 1'b0;
			end
			if (stAcc) begin
				s_nxt.armAny  = 1'b1;
				s_nxt.armRead = ~pwrite;
			end
			// Bit 7 is hardware-owned; software cannot forge a ninth bit.
			if (ctrlWr) begin
				s_nxt.ctrl = {s_r.ctrl[ups_pkg::CTL_RX9], pwdata[6:0]};
			end
			if (dataWr) begin
				s_nxt.txHold   = pwdata[7:0];
				s_nxt.holdFull = 1'b1;
			end
			// Holding register moves to the shifter.
			if (txEvt.load && s_r.txValid) begin
				s_nxt.status[ups_pkg::BIT_TXE] = 1'b1;
				s_nxt.holdFull = 1'b0;
			end
			// Preamble and break frames leave transmit-done alone.
			if (txEvt.frameDone && txEvt.frameIsData) begin
				s_nxt.status[ups_pkg::BIT_TXD] = 1'b1;
			end
			// Completed received word.
			if (rxEvt.done) begin
				if (s_nxt.status[ups_pkg::BIT_RXF]) begin
					s_nxt.status[ups_pkg::BIT_OVR] = 1'b1;
				end else begin
					s_nxt.rxHold = rxEvt.word[7:0];
					s_nxt.status[ups_pkg::BIT_RXF] = 1'b1;
					s_nxt.idleArmed = 1'b1;
					if (s_r.rxCfg.longWord) begin
						s_nxt.ctrl[ups_pkg::CTL_RX9] = rxEvt.word[8];
					end
					if (rxEvt.noise) begin
						s_nxt.status[ups_pkg::BIT_NOISE] = 1'b1;
					end
					if (rxEvt.frameErr) begin
						s_nxt.status[ups_pkg::BIT_FRAME] = 1'b1;
					end
					if (s_r.rxCfg.parityOn && rxMismatch) begin
						s_nxt.status[ups_pkg::BIT_PAR] = 1'b1;
					end
				end
				// Top data bit, which sits below the parity bit when parity is on.
				case ({s_r.rxCfg.longWord, s_r.rxCfg.parityOn})
					2'b00:   s_nxt.addrMark = rxEvt.word[7];
					2'b01:   s_nxt.addrMark = rxEvt.word[6];
					2'b10:   s_nxt.addrMark = rxEvt.word[8];
					default: s_nxt.addrMark = rxEvt.word[7];
				endcase
			end
			// Idle is reported once per received burst.
			if (rxEvt.idle && s_r.idleArmed) begin
				s_nxt.status[ups_pkg::BIT_IDLE] = 1'b1;
				s_nxt.idleArmed = 1'b0;
			end
			// Format changes reach each direction only between bytes.
			if (!txBusy) begin
				s_nxt.txCfg = ctlCfg;
			end
			if (!rxBusy) begin
				s_nxt.rxCfg = ctlCfg;
			end
			// Outgoing word with ninth bit and parity inserted at the MSB.
			s_nxt.txWord = {1'b0, s_r.txHold};
			if (s_r.txCfg.longWord) begin
				s_nxt.txWord[8] = s_r.ctrl[ups_pkg::CTL_TX9];
			end
			if (s_r.txCfg.parityOn && s_r.txCfg.longWord) begin
				s_nxt.txWord[8] = ups_pkg::parityBit({1'b0, s_r.txHold},
					s_r.txCfg);
			end else if (s_r.txCfg.parityOn) begin
				s_nxt.txWord[7] = ups_pkg::parityBit({1'b0, s_r.txHold},
					s_r.txCfg);
			end
			// No hand-over to the shifter while transmit-empty stands.
			s_nxt.txValid = s_nxt.holdFull
				& ~s_nxt.status[ups_pkg::BIT_TXE];
		end
		// Shared request and wake-up; halt never wakes.
		s_nxt.irq  = pending & ~irqMask;
		s_nxt.wake = pending & waitMode & ~haltMode;
		// Low-power stopping waits for the shifters so the last byte is not cut; halt stops at once.
		if (haltMode) begin
			s_nxt.run = 1'b0;
		end else if (!s_r.ctrl[ups_pkg::CTL_LPOFF]) begin
			s_nxt.run = 1'b1;
		end else if (!txBusy && !rxBusy) begin
			s_nxt.run = 1'b0;
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_r           <= '0;
			s_r.status    <= ups_pkg::STATUS_RST;
			s_r.ctrl      <= ups_pkg::CTRL1_RST;
			s_r.run       <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs, all taken directly from state flip-flops.
	assign prdata      = {24'h000000, s_r.prdata};
	assign pready      = s_r.pready;
	assign pslverr     = s_r.pslverr;
	assign txWord      = s_r.txWord;
	assign txWordValid = s_r.txValid;
	assign rxAddrMark  = s_r.addrMark;
	assign wakeByAddr  = s_r.ctrl[ups_pkg::CTL_WAKE];
	assign irqReq      = s_r.irq;
	assign wakeReq     = s_r.wake;
	assign serialRun   = s_r.run;

	// Checks on the block's own behaviour.
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence sHaltHeld;
		haltMode ##1 haltMode;
	endsequence

	sequence sOverrunWord;
		rxEvt.done && !haltMode && s_r.status[ups_pkg::BIT_RXF] && !rxClr;
	endsequence

	AST_STATUS_RESET: assert property ($fell(sys_rst) |->
		s_r.status == 8'hc0)
		else $error("status not c0 after reset");

	AST_TXE_SET: assert property (txEvt.load && s_r.txValid && !haltMode
		|=> s_r.status[ups_pkg::BIT_TXE])
		else $error("transmit-empty not set on load");

	AST_NO_TRANSFER: assert property (s_r.status[ups_pkg::BIT_TXE]
		|-> !txWordValid)
		else $error("word offered while transmit-empty set");

	AST_TXD_NOT_BREAK: assert property (txEvt.frameDone &&
		!txEvt.frameIsData && !s_r.status[ups_pkg::BIT_TXD]
		|=> !s_r.status[ups_pkg::BIT_TXD])
		else $error("transmit-done set after non-data frame");

	AST_OVERRUN: assert property (sOverrunWord |=>
		s_r.status[ups_pkg::BIT_OVR] && $stable(s_r.rxHold) &&
		$stable(s_r.status[ups_pkg::BIT_FRAME]))
		else $error("overrun handling wrong");

	AST_TX_PARITY: assert property ($past(s_r.txCfg.parityOn) &&
		!$past(s_r.txCfg.longWord) && !$past(haltMode) |->
		(^txWord[7:0]) == $past(s_r.txCfg.parityOdd))
		else $error("transmitted short-word parity wrong");

	AST_IRQ_GATE: assert property (irqReq |-> $past(pending) &&
		!$past(irqMask))
		else $error("interrupt without enabled event");

	AST_HALT_FREEZE: assert property (sHaltHeld |->
		$stable(s_r.status) && $stable(s_r.ctrl) && !serialRun && !wakeReq)
		else $error("state moved or woke during halt");

	AST_IDLE_ONCE: assert property (rxEvt.idle && !s_r.idleArmed
		&& !rxClr |=> $stable(s_r.status[ups_pkg::BIT_IDLE]))
		else $error("idle set twice without new word");

	AST_LOW_POWER: assert property (s_r.ctrl[ups_pkg::CTL_LPOFF] &&
		!txBusy && !rxBusy ##1 !txBusy && !rxBusy |-> !serialRun)
		else $error("serial logic still running in low power");

endmodule

// *** ups_shifter_model.sv ***
// Model of the transmit and receive shifters that face the block.
`timescale 1ns/1ps
module ups_shifter_model (
	// Clock.
	input  wire logic            clock,
	// Transmit side.
	input  wire logic [8:0]      txWord,
	input  wire logic            txWordValid,
	output ups_pkg::ups_tx_evt_t txEvt,
	output logic                 txBusy,
	// Receive side.
	output ups_pkg::ups_rx_evt_t rxEvt,
	output logic                 rxBusy
);
	logic [8:0] lastTx;

	// Takes a held word, then spends ten bit times on one data frame.
	initial begin
		txEvt = '0;
		txBusy = 1'b0;
		rxEvt = '0;
		rxBusy = 1'b0;
		lastTx = '0;
		forever begin
			@(posedge clock);
			if (txWordValid === 1'b1) begin
				txEvt.load <= 1'b1;
				txBusy <= 1'b1;
				@(posedge clock);
				lastTx = txWord;
				txEvt.load <= 1'b0;
				repeat (10) @(posedge clock);
				txEvt.frameDone <= 1'b1;
				txEvt.frameIsData <= 1'b1;
				@(posedge clock);
				txEvt <= '0;
				txBusy <= 1'b0;
			end
		end
	end

	// Word lines carry the inverse outside the done pulse, so stale use shows.
	task automatic rxSend(input logic [8:0] w, input logic n, input logic f);
		rxBusy <= 1'b1;
		repeat (10) @(posedge clock);
		rxEvt <= '{1'b1, w, n, f, 1'b0};
		rxBusy <= 1'b0;
		@(posedge clock);
		rxEvt <= '{1'b0, ~w, ~n, ~f, 1'b0};
	endtask

	// A break or preamble frame ends; it must never count as a data frame.
	task automatic breakDone();
		txEvt.frameDone <= 1'b1;
		@(posedge clock);
		txEvt.frameDone <= 1'b0;
	endtask

	// The line has gone idle after a frame.
	task automatic idle();
		rxEvt.idle <= 1'b1;
		@(posedge clock);
		rxEvt.idle <= 1'b0;
	endtask
endmodule

// *** ups_parity_status_bench.sv ***
// Self-checking bench for the parity, status and control block.
`timescale 1ns/1ps
module ups_parity_status_bench;
	logic                 clock, sys_rst, psel, penable, pwrite, pready;
	logic                 pslverr, txWordValid, txBusy, rxBusy, rxAddrMark;
	logic                 wakeByAddr, irqMask, waitMode, haltMode, irqReq;
	logic                 wakeReq, serialRun, e;
	logic [7:0]           paddr, q;
	logic [31:0]          pwdata, prdata;
	logic [8:0]           txWord;
	ups_pkg::ups_tx_evt_t txEvt;
	ups_pkg::ups_rx_evt_t rxEvt;
	ups_pkg::ups_irq_en_t irqEn;
	int                   failures, cmpCount;

	ups_parity_status i_dut (.clock, .sys_rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .txEvt, .txBusy, .txWord,
		.txWordValid, .rxEvt, .rxBusy, .rxAddrMark, .wakeByAddr, .irqEn,
		.irqMask, .waitMode, .haltMode, .irqReq, .wakeReq, .serialRun);
	ups_shifter_model i_partner (.clock, .txWord, .txWordValid, .txEvt,
		.txBusy, .rxEvt, .rxBusy);

	// Clock at 10 MHz.
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic chk(input string nm, input logic [8:0] x,
		input logic [8:0] g);
		cmpCount++;
		if (g !== x) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic chkb(input string nm, input logic x, input logic g);
		chk(nm, {8'h00, x}, {8'h00, g});
	endtask

	// One transfer; the request is held until pready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		tick(1);
		penable <= 1'b1;
		tick(1);
		while (pready !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		if (n == 20) failures++;
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tick(1);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [8:0] x);
		apb(1'b0, a, 8'h00);
		chk($sformatf("reg %h", a), x, {1'b0, q});
	endtask

	task automatic st(input logic [8:0] x);
		rdc(ups_pkg::ADDR_STATUS, x);
	endtask

	task automatic dr(input logic [8:0] x);
		rdc(ups_pkg::ADDR_DATA, x);
	endtask

	task automatic cw(input logic [7:0] d);
		apb(1'b1, ups_pkg::ADDR_CTRL1, d);
	endtask

	// Clear sequence, data write, then watch the frame leave.
	task automatic send(input logic [7:0] d, input logic [8:0] x);
		int n;
		st(9'h0c0);
		apb(1'b1, ups_pkg::ADDR_DATA, d);
		for (n = 0; n < 50 && txBusy !== 1'b1; n++) tick(1);
		i_partner.breakDone();                 // Non-data frame.
		st(9'h080);                            // Frame in flight.
		for (n = 0; n < 50 && txBusy !== 1'b0; n++) tick(1);
		tick(2);
		chk("txWord", x, i_partner.lastTx);
		st(9'h0c0);                            // Frame done.
	endtask

	task automatic close_out;
		$display("Compares %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Cuts a hang short; the tests need well under a thousand cycles.
	initial begin
		tick(5000);
		failures++;
		close_out;
	end

	// Main sequence.
	initial begin
		failures = 0;
		cmpCount = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		irqEn = '0;
		{irqMask, waitMode, haltMode} = 3'b000;
		sys_rst = 1'b1;
		tick(3);
		sys_rst <= 1'b0;
		tick(1);
		st(9'h0c0);                            // Reset value.
		rdc(ups_pkg::ADDR_CTRL1, 9'h000);
		apb(1'b0, 8'h0c, 8'h00);
		chkb("pslverr", 1'b1, e);
		cw(8'h2c);                             // Address mark.
		tick(2);
		chkb("serialRun", 1'b0, serialRun);    // Low power.
		chkb("wakeByAddr", 1'b1, wakeByAddr);  // Wake method.
		rdc(ups_pkg::ADDR_CTRL1, 9'h02c);
		cw(8'h04);
		send(8'hb5, 9'h035);                   // Even parity.
		cw(8'h06);
		send(8'h35, 9'h0b5);                   // Odd parity.
		// Four ones under odd parity must be caught.
		cw(8'h07);
		i_partner.rxSend(9'h035, 1'b0, 1'b0);
		tick(2);
		chkb("irqReq", 1'b1, irqReq);          // Parity irq.
		st(9'h0e1);                            // Flags.
		dr(9'h035);                            // Clear.
		tick(2);
		chkb("irqReq", 1'b0, irqReq);          // Cleared.
		st(9'h0c0);                            // Cleared.
		// Second word while full; its framing fault must not show.
		irqEn.rx <= 1'b1;
		i_partner.rxSend(9'h0b5, 1'b0, 1'b0);
		i_partner.rxSend(9'h011, 1'b0, 1'b1);
		tick(2);
		chkb("irqReq", 1'b1, irqReq);          // Receive irq.
		st(9'h0e8);                            // Overrun.
		dr(9'h0b5);                            // Holding kept.
		i_partner.rxSend(9'h080, 1'b1, 1'b0);
		st(9'h0e4);                            // Noise.
		chkb("rxAddrMark", 1'b0, rxAddrMark);  // Not the parity.
		dr(9'h080);
		i_partner.idle();
		st(9'h0d0);                            // Idle once.
		dr(9'h080);
		i_partner.idle();
		st(9'h0c0);                            // No second idle.
		// Long words carry a ninth bit both ways.
		cw(8'h10);                             // Between frames.
		i_partner.rxSend(9'h1aa, 1'b0, 1'b0);
		rdc(ups_pkg::ADDR_CTRL1, 9'h090);      // Ninth bit in.
		chkb("rxAddrMark", 1'b1, rxAddrMark);  // Top data bit.
		st(9'h0e0);
		dr(9'h0aa);
		cw(8'h50);
		send(8'h12, 9'h112);                   // Ninth bit out.
		// Wait, mask and halt.
		irqEn.rx <= 1'b0;
		irqEn.txEmpty <= 1'b1;
		waitMode <= 1'b1;
		tick(3);
		chkb("wakeReq", 1'b1, wakeReq);        // Wait wake.
		chkb("irqReq", 1'b1, irqReq);          // Enabled event.
		irqMask <= 1'b1;
		tick(3);
		chkb("irqReq", 1'b0, irqReq);          // Masked.
		haltMode <= 1'b1;
		tick(3);
		chkb("wakeReq", 1'b0, wakeReq);        // No halt wake.
		chkb("serialRun", 1'b0, serialRun);    // Halt stops.
		cw(8'h00);
		haltMode <= 1'b0;
		tick(2);
		rdc(ups_pkg::ADDR_CTRL1, 9'h0d0);      // Frozen.
		close_out;
	end
endmodule
